// [shared/kst_defines.svh]
/*
 Register indexes, field positions, reset values and segment constants
 of the kernel segment translation block.
 Assumes inclusion by bare name from a package or a module.
*/
`ifndef KST_DEFINES_SVH
`define KST_DEFINES_SVH
// Register indexes; byte address is four times the index
`define KST_IDX_TLBCMD  8'h00
`define KST_IDX_LO_EVEN 8'h02
`define KST_IDX_LO_ODD  8'h03
`define KST_IDX_PMASK   8'h05
`define KST_IDX_HI      8'h0a
`define KST_IDX_STATUS  8'h0c
`define KST_IDX_CONFIG  8'h10
// Field positions
`define KST_ST_EXL      1
`define KST_ST_ERL      2
`define KST_CMD_RD      8
// Reset values
`define KST_ST_RST      4'h2
`define KST_K0_RST      3'h2
// Sizes and codes
`define KST_TLB_N       48
`define KST_PRIV_KERNEL 2'h0
`define KST_SEG_KC      3'h4
`define KST_SEG_KU      3'h5
`define KST_OFS_KC      32'h8000_0000
`define KST_OFS_KU      32'ha000_0000
`endif

// [shared/kst_pkg.sv]
/*
 Types of the kernel segment translation block.
 Assumes kst_defines.svh on the include path.
*/
`default_nettype none
package kst_pkg;
  `include "kst_defines.svh"
  // Page coherency attribute
  typedef enum logic [2:0] {
    KST_C_RSV0 = 3'b000, KST_C_RSV1 = 3'b001, KST_C_UNC  = 3'b010,
    KST_C_WBA  = 3'b011, KST_C_RSV4 = 3'b100, KST_C_RSV5 = 3'b101,
    KST_C_RSV6 = 3'b110, KST_C_ACC  = 3'b111
  } kst_attr_t;
  typedef struct packed {
    logic [18:0] virtual_pair_number;  logic [7:0] tag;  logic [11:0] mask; logic g;
    logic [19:0] pfn0;  kst_attr_t c0;    logic d0;          logic v0;
    logic [19:0] pfn1;  kst_attr_t c1;    logic d1;          logic v1;
  } kst_ent_t;
  typedef struct packed {
    logic valid; logic load; logic store; logic [31:0] vaddr;
    logic [127:0] wdata; logic [15:0] wbe;
  } kst_req_t;
  typedef struct packed {
    logic valid; logic [31:0] paddr; logic mapped; kst_attr_t attr;
    logic cached; logic wr_alloc; logic miss; logic invalid;
    logic modified; logic uncached_prefetch_buffer_hit; logic [127:0] rdata;
  } kst_rsp_t;
  typedef struct packed {
    logic valid; logic [27:0] addr; logic [127:0] data; logic [15:0] be;
  } kst_gath_t;
  typedef struct packed { logic valid; logic [24:0] blk; } kst_fetch_t;
  typedef struct packed { logic valid; logic [2:0] qw; logic [127:0] data; } kst_fill_t;
endpackage
`default_nettype wire

// [rtl/kst_mmu.sv]
/*
 Kernel segment decode, 48-entry translation buffer with its entry
 registers, uncached-accelerated read buffer and store gathering.
 Assumes a load/store pipeline and memory bus on core_clk_i, and an
 AHB-Lite master for the register file.
*/
// Summary of operation
// - Kernel when privilege 00, EXCEPTION_LEVEL_BIT or ERROR_LEVEL_BIT.
// - Exception enters kernel; return restores prior mode.
// - Kernel A31 clear maps user region with tag.
// - ERROR_LEVEL_BIT makes user region unmapped, uncached, identity.
// - Top 100 bypasses buffer, minus 0x80000000, K0.
// - Top 101 bypasses buffer, minus 0xA0000000, uncached.
// - Top 110 maps supervisor region with tag.
// - Top 111 maps kernel top region with tag.
// - Buffer holds 48 entries from entry registers.
// - Registers numbered; page mask is number 5.
// - Process space tag is 8 bits.
// - Entry-high holds pair number; global bit reserved.
// - Global only if both low registers set it.
// - Reserved register bits read as zero.
// - Dirty bit grants write permission.
// - Matching invalid entry raises invalid exception.
// - Attribute 2 uncached, 3 write-allocate, 7 accelerated.
// - Write-allocate stores stay in data cache.
// - Accelerated load miss fetches aligned 128-byte block.
// - Read buffer dropped on miss, store, barrier, exception.
// - Accelerated stores merge within one 128-bit entry.
// - Gathering ends on mismatch, load, barrier, exception.
// - No match raises miss; bad bits raise exceptions.
`timescale 1ns/1ps
`default_nettype none
`include "kst_defines.svh"
module kst_mmu
  import kst_pkg::*;
(
  input  wire logic        core_clk_i,  // Core clock, 25 MHz
  input  wire logic        sys_rst_i,   // Synchronous reset, high
  input  wire logic        clk_en_i,    // Freezes all state when low
  input  wire logic        hsel_i,      // AHB select
  input  wire logic [31:0] haddr_i,     // AHB address
  input  wire logic [1:0]  htrans_i,    // AHB transfer type
  input  wire logic        hwrite_i,    // AHB write
  input  wire logic [2:0]  hsize_i,     // AHB size, word only
  input  wire logic [31:0] hwdata_i,    // AHB write data
  input  wire logic        hready_i,    // AHB bus ready
  output logic             hreadyout_o, // AHB slave ready
  output logic             hresp_o,     // AHB response, always OKAY
  output logic [31:0]      hrdata_o,    // AHB read data
  input  wire kst_req_t    req_i,       // Pipeline access request
  input  wire logic        exc_i,       // Exception detected, pulse
  input  wire logic        exception_return_op_i,      // Exception return, pulse
  input  wire logic        sync_i,      // Memory barrier, pulse
  output kst_rsp_t         rsp_o,       // Translation result
  output logic             kernel_o,    // Kernel mode level
  output kst_fetch_t       fetch_o,     // Block fetch request pulse
  input  wire kst_fill_t   fill_i,      // Block fill quadwords
  output kst_gath_t        gath_o       // Gathered store push pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  kst_ent_t     tlb_r [0:`KST_TLB_N-1];
  logic [18:0]  hi_virtual_pair_number_r;
  logic [7:0]   hi_tag_r;
  logic [11:0]  pmask_r;
  logic [25:0]  lo_even_r;
  logic [25:0]  lo_odd_r;
  logic [5:0]   tlb_idx_r;
  logic [1:0]   priv_r;
  logic         exl_r;
  logic         erl_r;
  kst_attr_t    k0_r;
  logic         ap_valid_r;
  logic         ap_wr_r;
  logic [7:0]   ap_idx_r;
  logic [31:0]  hrdata_r;
  logic         ub_valid_r;
  logic         ub_pend_r;
  logic [24:0]  ub_blk_r;
  logic [127:0] ub_mem_r [0:7];
  kst_gath_t    gath_r;
  kst_gath_t    push_r;
  kst_fetch_t   fetch_r;
  kst_rsp_t     rsp_r;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        ap_take;
  logic        ap_hit;
  logic [7:0]  ap_idx;
  logic        wr_do;
  logic [31:0] rd_val;

  // Zero wait state; the frozen clock holds the master off
  assign hreadyout_o = clk_en_i;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_r;
  assign ap_take     = hsel_i & htrans_i[1] & hready_i & clk_en_i;
  assign ap_idx      = haddr_i[9:2];
  assign ap_hit      = (haddr_i[31:10] == 22'h0) & (haddr_i[1:0] == 2'h0);
  assign wr_do       = ap_valid_r & ap_wr_r & clk_en_i;

  // Read mux; reserved bits and unmapped words return zero
  always_comb begin
    rd_val = 32'h0;
    unique case (ap_idx)
      `KST_IDX_TLBCMD:  rd_val = {26'h0, tlb_idx_r};
      `KST_IDX_LO_EVEN: rd_val = {6'h0, lo_even_r};
      `KST_IDX_LO_ODD:  rd_val = {6'h0, lo_odd_r};
      `KST_IDX_PMASK:   rd_val = {7'h0, pmask_r, 13'h0};
      `KST_IDX_HI:      rd_val = {hi_virtual_pair_number_r, 5'h0, hi_tag_r};
      `KST_IDX_STATUS:  rd_val = {24'h0, ub_pend_r, gath_r.valid, ub_valid_r,
                                  priv_r, erl_r, exl_r, kernel_o};
      `KST_IDX_CONFIG:  rd_val = {29'h0, k0_r};
      default:          rd_val = 32'h0;
    endcase
  end

  // Address phase capture; read data is latched a cycle early
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ap_valid_r <= 1'b0;
      ap_wr_r    <= 1'b0;
      ap_idx_r   <= 8'h0;
      hrdata_r   <= 32'h0;
    end else if (clk_en_i) begin
      ap_valid_r <= ap_take & ap_hit;
      ap_wr_r    <= hwrite_i;
      ap_idx_r   <= ap_idx;
      hrdata_r   <= (ap_take & ap_hit & ~hwrite_i) ? rd_val : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  assign kernel_o = (priv_r == `KST_PRIV_KERNEL) | exl_r | erl_r;

  // Exception level wins over a software write in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      {priv_r, erl_r, exl_r} <= `KST_ST_RST;
      k0_r                   <= kst_attr_t'(`KST_K0_RST);
    end else if (clk_en_i) begin
      if (wr_do && ap_idx_r == `KST_IDX_STATUS)
        {priv_r, erl_r, exl_r} <= hwdata_i[4:1];
      if (wr_do && ap_idx_r == `KST_IDX_CONFIG)
        k0_r <= kst_attr_t'(hwdata_i[2:0]);
      if (exc_i)
        exl_r <= 1'b1;
      else if (exception_return_op_i && erl_r)
        erl_r <= 1'b0;
      else if (exception_return_op_i)
        exl_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Entry registers and buffer write/read commands
  // ----------------------------------------------------------------
  logic     cmd_wr;
  logic     cmd_ok;
  logic [5:0] cmd_idx;
  kst_ent_t new_ent;

  assign cmd_wr  = wr_do & (ap_idx_r == `KST_IDX_TLBCMD);
  assign cmd_idx = hwdata_i[5:0];
  assign cmd_ok  = cmd_idx < 6'(`KST_TLB_N);
  // Global is kept only if both low halves carry it
  assign new_ent = '{virtual_pair_number: hi_virtual_pair_number_r, tag: hi_tag_r, mask: pmask_r,
                     g: lo_even_r[0] & lo_odd_r[0],
                     pfn0: lo_even_r[25:6], c0: kst_attr_t'(lo_even_r[5:3]),
                     d0: lo_even_r[2], v0: lo_even_r[1],
                     pfn1: lo_odd_r[25:6], c1: kst_attr_t'(lo_odd_r[5:3]),
                     d1: lo_odd_r[2], v1: lo_odd_r[1]};

  // Software side of the entry fields; a read command reloads them
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      hi_virtual_pair_number_r <= 19'h0;
      hi_tag_r  <= 8'h0;
      pmask_r   <= 12'h0;
      lo_even_r <= 26'h0;
      lo_odd_r  <= 26'h0;
      tlb_idx_r <= 6'h0;
    end else if (clk_en_i && wr_do) begin
      unique case (ap_idx_r)
        `KST_IDX_HI: begin
          hi_virtual_pair_number_r <= hwdata_i[31:13];
          hi_tag_r  <= hwdata_i[7:0];
        end
        `KST_IDX_PMASK:   pmask_r   <= hwdata_i[24:13];
        `KST_IDX_LO_EVEN: lo_even_r <= hwdata_i[25:0];
        `KST_IDX_LO_ODD:  lo_odd_r  <= hwdata_i[25:0];
        `KST_IDX_TLBCMD: if (cmd_ok) begin
          tlb_idx_r <= cmd_idx;
          if (hwdata_i[`KST_CMD_RD]) begin
            hi_virtual_pair_number_r <= tlb_r[cmd_idx].virtual_pair_number;
            hi_tag_r  <= tlb_r[cmd_idx].tag;
            pmask_r   <= tlb_r[cmd_idx].mask;
            lo_even_r <= {tlb_r[cmd_idx].pfn0, tlb_r[cmd_idx].c0,
                          tlb_r[cmd_idx].d0, tlb_r[cmd_idx].v0,
                          tlb_r[cmd_idx].g};
            lo_odd_r  <= {tlb_r[cmd_idx].pfn1, tlb_r[cmd_idx].c1,
                          tlb_r[cmd_idx].d1, tlb_r[cmd_idx].v1,
                          tlb_r[cmd_idx].g};
          end
        end
        default: ;
      endcase
    end
  end

  // Buffer array; entries come up invalid
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `KST_TLB_N; i++)
        tlb_r[i] <= '0;
    end else if (clk_en_i && cmd_wr && cmd_ok && !hwdata_i[`KST_CMD_RD]) begin
      tlb_r[cmd_idx] <= new_ent;
    end
  end

  // ----------------------------------------------------------------
  // Segment decode and lookup
  // ----------------------------------------------------------------
  logic [31:0] va;
  logic [31:0] pa;
  logic        mapped;
  logic        hit;
  logic        odd;
  logic [12:0] msel;
  logic [19:0] mpfn;
  kst_attr_t   attr;
  logic        pg_d;
  logic        pg_v;
  logic        miss;
  logic        inval;
  logic        modif;

  assign va = req_i.vaddr;

  always_comb begin
    pa     = va;
    mapped = 1'b0;
    attr   = KST_C_UNC;
    hit    = 1'b0;
    odd    = 1'b0;
    msel   = 13'h0;
    mpfn   = 20'h0;
    pg_d   = 1'b0;
    pg_v   = 1'b0;
    if (!va[31]) begin
      mapped = !erl_r;
    end else if (va[31:29] == `KST_SEG_KC) begin
      pa   = va - `KST_OFS_KC;
      attr = k0_r;
    end else if (va[31:29] == `KST_SEG_KU) begin
      pa   = va - `KST_OFS_KU;
    end else begin
      mapped = 1'b1;
    end
    // First matching entry wins; tag ignored for global entries
    for (int i = 0; i < `KST_TLB_N; i++) begin
      if (mapped && !hit &&
          ((tlb_r[i].virtual_pair_number & ~{7'h0, tlb_r[i].mask}) ==
           (va[31:13] & ~{7'h0, tlb_r[i].mask})) &&
          (tlb_r[i].g || tlb_r[i].tag == hi_tag_r)) begin
        hit  = 1'b1;
        msel = {tlb_r[i].mask, 1'b1} & ~{1'b0, tlb_r[i].mask};
        odd  = |(va[24:12] & msel);
        mpfn = odd ? tlb_r[i].pfn1 : tlb_r[i].pfn0;
        attr = odd ? tlb_r[i].c1 : tlb_r[i].c0;
        pg_d = odd ? tlb_r[i].d1 : tlb_r[i].d0;
        pg_v = odd ? tlb_r[i].v1 : tlb_r[i].v0;
        pa   = {(mpfn & ~{7'h0, tlb_r[i].mask, 1'b0}) |
                (va[31:12] & {7'h0, tlb_r[i].mask, 1'b0}), va[11:0]};
      end
    end
  end

  assign miss  = mapped & !hit;
  assign inval = mapped & hit & !pg_v;
  assign modif = mapped & hit & pg_v & req_i.store & !pg_d;

  // ----------------------------------------------------------------
  // Uncached-accelerated read buffer
  // ----------------------------------------------------------------
  logic acc_ok;
  logic ld_acc;
  logic ub_hit;
  logic ub_kill;

  assign acc_ok  = req_i.valid & !miss & !inval & !modif;
  assign ld_acc  = acc_ok & req_i.load & (attr == KST_C_ACC);
  assign ub_hit  = ub_valid_r & (ub_blk_r == pa[31:7]);
  assign ub_kill = (req_i.valid & req_i.load & !(ld_acc & ub_hit)) |
                   (req_i.valid & req_i.store) | sync_i | exc_i;

  // A kill drops a fill in flight so stale data never goes valid
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ub_valid_r <= 1'b0;
      ub_pend_r  <= 1'b0;
      ub_blk_r   <= 25'h0;
      fetch_r    <= '0;
    end else if (clk_en_i) begin
      fetch_r.valid <= 1'b0;
      if (ub_kill) begin
        ub_valid_r <= 1'b0;
        ub_pend_r  <= 1'b0;
      end else if (ub_pend_r && fill_i.valid && fill_i.qw == 3'h7) begin
        ub_valid_r <= 1'b1;
        ub_pend_r  <= 1'b0;
      end
      if (ld_acc && !ub_hit && !sync_i && !exc_i) begin
        ub_pend_r     <= 1'b1;
        ub_blk_r      <= pa[31:7];
        fetch_r.valid <= 1'b1;
        fetch_r.blk   <= pa[31:7];
      end
    end
  end

  // Eight quadwords of the block, indexed by qw; quadword 7 must arrive last
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 8; i++)
        ub_mem_r[i] <= 128'h0;
    end else if (clk_en_i && ub_pend_r && fill_i.valid) begin
      ub_mem_r[fill_i.qw] <= fill_i.data;
    end
  end

  // ----------------------------------------------------------------
  // Store gathering
  // ----------------------------------------------------------------
  logic st_acc;
  logic g_same;
  logic g_end;

  assign st_acc = acc_ok & req_i.store & (attr == KST_C_ACC);
  assign g_same = gath_r.valid & (gath_r.addr == pa[31:4]);
  // Any load, barrier, exception or unmergeable store closes it
  assign g_end  = gath_r.valid & ((req_i.valid & req_i.load) | sync_i | exc_i |
                  (req_i.valid & req_i.store & !(st_acc & g_same)));

  // The closed entry leaves as a one-cycle push with no back-pressure
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      gath_r <= '0;
      push_r <= '0;
    end else if (clk_en_i) begin
      push_r.valid <= 1'b0;
      if (g_end) begin
        push_r       <= gath_r;
        gath_r.valid <= 1'b0;
      end
      if (st_acc && g_same && !sync_i && !exc_i) begin
        for (int b = 0; b < 16; b++)
          if (req_i.wbe[b])
            gath_r.data[b*8 +: 8] <= req_i.wdata[b*8 +: 8];
        gath_r.be <= gath_r.be | req_i.wbe;
      end else if (st_acc && !sync_i && !exc_i) begin
        gath_r <= '{valid: 1'b1, addr: pa[31:4],
                    data: req_i.wdata, be: req_i.wbe};
      end
    end
  end

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  // Registered so data outputs come straight from flip-flops
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rsp_r <= '0;
    end else if (clk_en_i) begin
      rsp_r.valid    <= req_i.valid;
      rsp_r.paddr    <= pa;
      rsp_r.mapped   <= mapped;
      rsp_r.attr     <= attr;
      rsp_r.cached   <= (attr == KST_C_WBA);
      rsp_r.wr_alloc <= (attr == KST_C_WBA);
      rsp_r.miss     <= req_i.valid & miss;
      rsp_r.invalid  <= req_i.valid & inval;
      rsp_r.modified <= req_i.valid & modif;
      rsp_r.uncached_prefetch_buffer_hit <= ld_acc & ub_hit;
      rsp_r.rdata    <= (ld_acc & ub_hit) ? ub_mem_r[pa[6:4]] : 128'h0;
    end
  end

  assign rsp_o  = rsp_r;
  assign fetch_o = fetch_r;
  assign gath_o = push_r;

endmodule // kst_mmu
`default_nettype wire

// [bench/kst_mmu_assertions.sv]
/*
 Port checker for kst_mmu, bound to every instance.
 Assumes clk_en_i is high whenever results are judged.
*/
`timescale 1ns/1ps
`default_nettype none
module kst_mmu_checker
  import kst_pkg::*;
(
  input wire logic       core_clk_i, // Core clock
  input wire logic       sys_rst_i,  // Reset, high
  input wire logic       clk_en_i,   // Clock enable
  input wire kst_req_t   req_i,      // Pipeline request
  input wire logic       exc_i,      // Exception pulse
  input wire kst_rsp_t   rsp_o,      // Translation result
  input wire logic       kernel_o,   // Kernel mode
  input wire kst_fetch_t fetch_o     // Block fetch
);
  // A frozen clock enable holds state, so nothing is judged then
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i || !clk_en_i);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_exc_kernel: assert property (exc_i |=> kernel_o)
    else $error("kernel mode not entered on exception");
  chk_kc_addr: assert property (req_i.valid && req_i.vaddr[31:29] == 3'h4 |=>
    !rsp_o.mapped && rsp_o.paddr == $past(req_i.vaddr) - 32'h8000_0000) else $error("cached window address");
  chk_ku_addr: assert property (req_i.valid && req_i.vaddr[31:29] == 3'h5 |=>
    !rsp_o.mapped && !rsp_o.cached && rsp_o.paddr == $past(req_i.vaddr) - 32'ha000_0000)
    else $error("uncached window address");
  chk_top_mapped: assert property (req_i.valid && req_i.vaddr[31:30] == 2'b11 |=> rsp_o.mapped)
    else $error("upper regions not mapped");
  chk_user_ident: assert property (rsp_o.valid && !rsp_o.mapped && !$past(req_i.vaddr[31]) |->
    rsp_o.paddr == $past(req_i.vaddr) && !rsp_o.cached) else $error("unmapped user address");
  chk_cached_attr: assert property (rsp_o.valid && rsp_o.mapped |-> rsp_o.cached == (rsp_o.attr == KST_C_WBA))
    else $error("cacheability against attribute");
  chk_miss_only: assert property (rsp_o.miss |-> rsp_o.mapped && !rsp_o.invalid && !rsp_o.modified)
    else $error("miss with other fault");
  chk_mod_store: assert property (rsp_o.valid && rsp_o.modified |-> $past(req_i.store))
    else $error("modified fault on a load");
  chk_hit_nofetch: assert property (rsp_o.uncached_prefetch_buffer_hit |-> !fetch_o.valid)
    else $error("fetch on a buffer hit");
  chk_fetch_blk: assert property (fetch_o.valid |-> fetch_o.blk == rsp_o.paddr[31:7])
    else $error("fetch block address");
  cov_hit: cover property (rsp_o.uncached_prefetch_buffer_hit);
  cov_fetch: cover property (fetch_o.valid);
  cov_mod: cover property (rsp_o.modified);
endmodule // kst_mmu_checker
bind kst_mmu kst_mmu_checker u_kst_mmu_checker (.core_clk_i, .sys_rst_i, .clk_en_i, .req_i, .exc_i, .rsp_o,
  .kernel_o, .fetch_o);
`default_nettype wire

// [bench/kst_mem_model.sv]
/*
 Memory bus model: answers block fetches with eight quadwords.
 Assumes one outstanding fetch; a new fetch restarts the burst.
*/
`timescale 1ns/1ps
`default_nettype none
module kst_mem_model
  import kst_pkg::*;
#(
  parameter int LAT = 3 // Slow answer delay
)
(
  input  wire logic       core_clk_i, // Core clock
  input  wire logic       sys_rst_i,  // Reset, high
  input  wire kst_fetch_t fetch_i,    // Block fetch
  output kst_fill_t       fill_o      // Quadword fill
);
  logic [24:0] blk_r;
  int          cnt_r;
  int          lat_r;
  // Prompt and slow answers alternate; idle data toggles so stale data never looks valid
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cnt_r  <= -1;
      lat_r  <= 0;
      fill_o <= '0;
    end else begin
      fill_o.valid <= 1'b0;
      fill_o.data  <= ~fill_o.data;
      if (fetch_i.valid) begin
        blk_r <= fetch_i.blk;
        cnt_r <= 0;
        lat_r <= (lat_r == 0) ? LAT : 0;
      end else if (cnt_r >= 0) begin
        cnt_r <= (cnt_r == lat_r + 7) ? -1 : cnt_r + 1;
        if (cnt_r >= lat_r) begin
          fill_o.valid <= 1'b1;
          fill_o.qw    <= 3'(cnt_r - lat_r);
          fill_o.data  <= {4{blk_r, 4'h0, 3'(cnt_r - lat_r)}};
        end
      end
    end
  end
endmodule // kst_mem_model
`default_nettype wire

// [bench/tb_top.sv]
/*
 Self-checking bench for kst_mmu with the memory bus model.
 Assumes package, design, checker and model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import kst_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, kern;
  logic [1:0]  htrans;
  logic [2:0]  ev;
  logic [31:0] haddr, hwdata, hrdata, rd_smp, r, v, va, seed;
  logic [127:0] wa, wb;
  kst_req_t    req;
  kst_rsp_t    rsp;
  kst_fetch_t  fetch;
  kst_fill_t   fill;
  kst_gath_t   gath;
  int          num_errors = 0;
  int          checks = 0;
  // ----------------------------------------
  // Clock, design and model
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  assign hready = hreadyout;
  kst_mmu u_kst_mmu (.core_clk_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .req_i(req), .exc_i(ev[0]), .exception_return_op_i(ev[1]),
    .sync_i(ev[2]), .rsp_o(rsp), .kernel_o(kern), .fetch_o(fetch), .fill_i(fill), .gath_o(gath));
  kst_mem_model #(.LAT(3)) u_kst_mem_model (.core_clk_i(clk), .sys_rst_i(rst), .fetch_i(fetch), .fill_o(fill));
  // Read data as it stood before each edge
  always @(posedge clk) rd_smp <= hrdata;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] lo(logic [19:0] f, logic [2:0] c, logic d, logic vb, logic g);
    return {6'h0, f, c, d, vb, g};
  endfunction
  function automatic logic [127:0] bm(logic [15:0] be);
    for (int i = 0; i < 16; i++) bm[8*i +: 8] = {8{be[i]}};
  endfunction
  task automatic cmp(logic [127:0] got, logic [127:0] exp, string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Single word transfer; the master waits for hready before each phase ends
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    #1 r = rd_smp;
  endtask
  task automatic rdc(logic [31:0] a, logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    cmp({r, hresp}, {e, 1'b0}, "register");
  endtask
  task automatic acc(logic ld, logic sto, logic [31:0] a, logic [127:0] wd, logic [15:0] be);
    @(posedge clk);
    req <= {1'b1, ld, sto, a, wd, be};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
  endtask
  task automatic pulse(logic [2:0] k);
    @(posedge clk);
    ev <= k;
    @(posedge clk);
    ev <= 3'h0;
    #1;
  endtask
  task automatic wrent(logic [31:0] ix, logic [31:0] hi, logic [31:0] le, logic [31:0] lod);
    ahb(1'b1, 32'h28, hi);
    ahb(1'b1, 32'h08, le);
    ahb(1'b1, 32'h0c, lod);
    ahb(1'b1, 32'h14, 32'h0);
    ahb(1'b1, 32'h00, ix);
  endtask
  task automatic summarize();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog sized well above the sequence length
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata, ev, r} = {1'b1, 103'h0};
    req = '0;
    seed = 32'd30923;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(32'h30, 32'h5);
    ahb(1'b1, 32'h04, 32'hffff_ffff);
    rdc(32'h04, 32'h0);
    ahb(1'b1, 32'h14, 32'hffff_ffff);
    rdc(32'h14, 32'h01ff_e000);
    ahb(1'b1, 32'h0c, 32'hffff_ffff);
    rdc(32'h0c, 32'h03ff_ffff);
    va = rnd() & 32'h7fff_fff0;
    acc(1'b1, 1'b0, va, 128'h0, 16'h0);
    cmp({rsp.mapped, rsp.cached, rsp.paddr}, {2'b00, va}, "error level user");
    // Mode changes: user mode, exception entry and return
    ahb(1'b1, 32'h30, 32'h10);
    cmp(kern, 1'b0, "user mode");
    pulse(3'h1);
    cmp(kern, 1'b1, "exception mode");
    pulse(3'h2);
    cmp(kern, 1'b0, "return mode");
    ahb(1'b1, 32'h30, 32'h0);
    cmp(kern, 1'b1, "kernel mode");
    ahb(1'b1, 32'h40, 32'h3);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      va = {2'b10, i[0], v[28:0]};
      acc(1'b1, 1'b0, va, 128'h0, 16'h0);
      cmp(rsp.paddr, va - (i[0] ? 32'ha000_0000 : 32'h8000_0000), "window address");
      cmp({rsp.mapped, rsp.cached}, {1'b0, ~i[0]}, "window cache");
    end
    // Two entries: one private accelerated, one global write-allocate
    wrent(32'h5, {19'h12, 5'h0, 8'h11}, lo(20'habc, 3'h7, 1'b1, 1'b1, 1'b1), lo(20'habd, 3'h2, 1'b1, 1'b0, 1'b0));
    wrent(32'h6, {19'h70001, 5'h0, 8'h33}, lo(20'h123, 3'h3, 1'b0, 1'b1, 1'b1), lo(20'h124, 3'h3, 1'b1, 1'b1, 1'b1));
    ahb(1'b1, 32'h00, 32'h105);
    rdc(32'h08, lo(20'habc, 3'h7, 1'b1, 1'b1, 1'b0));
    rdc(32'h28, {19'h12, 5'h0, 8'h11});
    acc(1'b1, 1'b0, 32'h0002_4010, 128'h0, 16'h0);
    cmp({rsp.mapped, rsp.miss, rsp.attr, rsp.paddr}, {2'b10, 3'h7, 32'h00ab_c010}, "user lookup");
    cmp({fetch.valid, fetch.blk}, {1'b1, 25'h01_5780}, "block fetch");
    r = 32'h0;
    for (int k = 0; k < 40 && r[5] !== 1'b1; k++) ahb(1'b0, 32'h30, 32'h0);
    cmp(r[5], 1'b1, "buffer filled");
    acc(1'b1, 1'b0, 32'h0002_4050, 128'h0, 16'h0);
    cmp({rsp.uncached_prefetch_buffer_hit, fetch.valid, rsp.rdata}, {2'b10, {4{25'h01_5780, 4'h0, 3'h5}}}, "buffer hit");
    pulse(3'h4);
    acc(1'b1, 1'b0, 32'h0002_4050, 128'h0, 16'h0);
    cmp(rsp.uncached_prefetch_buffer_hit, 1'b0, "barrier drop");
    acc(1'b1, 1'b0, 32'h0002_5010, 128'h0, 16'h0);
    cmp(rsp.invalid, 1'b1, "invalid page");
    acc(1'b0, 1'b1, 32'he000_2040, 128'h0, 16'h1);
    cmp({rsp.modified, rsp.cached, rsp.wr_alloc, rsp.paddr}, {3'b111, 32'h0012_3040}, "protected");
    acc(1'b0, 1'b1, 32'he000_3040, 128'h0, 16'h1);
    cmp({rsp.modified, rsp.miss, rsp.paddr}, {2'b00, 32'h0012_4040}, "global write");
    acc(1'b1, 1'b0, 32'hc000_0000, 128'h0, 16'h0);
    cmp({rsp.mapped, rsp.miss}, 2'b11, "supervisor miss");
    ahb(1'b1, 32'h28, 32'h22);
    acc(1'b1, 1'b0, 32'h0002_4010, 128'h0, 16'h0);
    cmp(rsp.miss, 1'b1, "other process");
    ahb(1'b1, 32'h28, 32'h11);
    // Gathering: merge two stores, break on address, flush on barrier
    wa = {rnd(), rnd(), rnd(), rnd()};
    wb = {rnd(), rnd(), rnd(), rnd()};
    acc(1'b0, 1'b1, 32'h0002_4100, wa, 16'h000f);
    acc(1'b0, 1'b1, 32'h0002_4104, wb, 16'h00f0);
    cmp(gath.valid, 1'b0, "merged");
    acc(1'b0, 1'b1, 32'h0002_4110, wb, 16'h000f);
    cmp({gath.valid, gath.addr, gath.be}, {1'b1, 28'h00a_bc10, 16'h00ff}, "address break");
    cmp(gath.data & bm(16'h00ff), (wa & bm(16'h000f)) | (wb & bm(16'h00f0)), "gathered data");
    pulse(3'h4);
    cmp({gath.valid, gath.addr, gath.be}, {1'b1, 28'h00a_bc11, 16'h000f}, "barrier push");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
